// *** cspr_pkg.sv ***
// Package of constants and types for the charge status pulse reporter
package cspr_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int STROBE_MIN_LOW_NS = 200;
	localparam int STROBE_MIN_CYC = (STROBE_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPORT_DELAY_NS = 10000;
	localparam int REPORT_DELAY_CYC = REPORT_DELAY_NS / CLK_PERIOD_NS;
	localparam int PULSE_PERIOD_NS = 4000;
	localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STROBE_MAX_NS = 100000;
	localparam int STROBE_MAX_CYC = STROBE_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	// ----------------------------------------
	// Pulse counts
	// ----------------------------------------
	localparam logic [4:0] N_DIE_HOT = 5'h01;
	localparam logic [4:0] N_BAT_TEMP = 5'h02;
	localparam logic [4:0] N_OVER_V = 5'h03;
	localparam logic [4:0] N_HIGH_BASE = 5'h0D;
	localparam logic [4:0] N_LOW_BASE = 5'h12;
	localparam logic [4:0] N_ERROR = 5'h17;
	// Charging phases
	typedef enum logic [2:0] {
		PH_COND, PH_REDUCE, PH_CC, PH_CV, PH_END, PH_NONE
	} cspr_phase_t;
endpackage

// *** cspr_reporter.sv ***
// Charge status pulse reporter on a shared open-drain status line
`timescale 1ns/1ps
// Function
// - Answer strobe with status pulse burst
// - Only pull line low, else release
// - Reply starts report delay after rise
// - Pulses at fixed period
// - Pulse count encodes one state
// - Counts 1-3 faults, 23 error
// - High setting counts 13 to 17
// - Low setting counts 18 to 22
// - Select input chooses current setting
module cspr_reporter #(
	parameter int REPORT_DELAY = cspr_pkg::REPORT_DELAY_CYC,
	parameter int PULSE_PERIOD = cspr_pkg::PULSE_PERIOD_CYC,
	parameter int STROBE_MAX = cspr_pkg::STROBE_MAX_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	// Shared status line
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	// Charger state
	input wire logic current_range_select,
	input wire logic die_over_temp,
	input wire logic bat_temp_fault,
	input wire logic over_voltage,
	input wire cspr_pkg::cspr_phase_t phase,
	// Status
	output logic busy
);
	typedef enum {ST_IDLE, ST_STROBE, ST_WAIT, ST_LOW, ST_HIGH} cspr_state_t;
	cspr_state_t state;
	logic [cspr_pkg::CNT_W-1:0] cnt;
	logic [4:0] left;
	logic [4:0] code;
	// Assertion helpers: cycles waited, pulled, released, pulses sent
	logic [cspr_pkg::CNT_W-1:0] wait_len;
	logic [cspr_pkg::CNT_W-1:0] low_len;
	logic [cspr_pkg::CNT_W-1:0] high_len;
	logic [4:0] sent;
	logic oe_d;

	// Status code from charger state
	function automatic logic [4:0] status_code(input logic hi, input logic dt, input logic bt,
		input logic ov, input cspr_pkg::cspr_phase_t ph);
		logic [4:0] base;
		base = hi ? cspr_pkg::N_HIGH_BASE : cspr_pkg::N_LOW_BASE;
		if (dt)
			return cspr_pkg::N_DIE_HOT;
		else if (bt)
			return cspr_pkg::N_BAT_TEMP;
		else if (ov)
			return cspr_pkg::N_OVER_V;
		else if (ph == cspr_pkg::PH_NONE)
			return cspr_pkg::N_ERROR;
		else
			return base + 5'(ph);
	endfunction

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Strobe detect, delay, pulse burst
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= '0;
			left <= '0;
			code <= '0;
		end else if (clk_en) begin
			case (state)
				ST_IDLE: begin
					cnt <= '0;
					if (!line_in)
						state <= ST_STROBE;
				end
				ST_STROBE: begin
					if (line_in) begin
						state <= ST_WAIT;
						cnt <= '0;
						code <= status_code(current_range_select, die_over_temp,
							bat_temp_fault, over_voltage, phase);
					end else if (cnt >= cspr_pkg::CNT_W'(STROBE_MAX - 1))
						state <= ST_IDLE;
					else
						cnt <= cnt + 1'b1;
				end
				ST_WAIT: begin
					if (cnt >= cspr_pkg::CNT_W'(REPORT_DELAY - 1)) begin
						state <= ST_LOW;
						cnt <= '0;
						left <= code;
					end else
						cnt <= cnt + 1'b1;
				end
				ST_LOW: begin
					if (cnt >= cspr_pkg::CNT_W'(PULSE_PERIOD / 2 - 1)) begin
						state <= ST_HIGH;
						cnt <= '0;
						left <= left - 1'b1;
					end else
						cnt <= cnt + 1'b1;
				end
				ST_HIGH: begin
					if (cnt >= cspr_pkg::CNT_W'(PULSE_PERIOD - PULSE_PERIOD / 2 - 1)) begin
						cnt <= '0;
						state <= (left == 5'h00) ? ST_IDLE : ST_LOW;
					end else
						cnt <= cnt + 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Line drive: only low, else released
	assign line_out = 1'b0;
	assign line_oe = (state == ST_LOW);
	assign busy = (state != ST_IDLE);

	// ----------------------------------------
	// Assertion helpers
	// ----------------------------------------
	// Report delay measured apart from the sequencer counter
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_len <= '0;
		end else if (clk_en) begin
			if (state == ST_WAIT)
				wait_len <= wait_len + 1'b1;
			else
				wait_len <= '0;
		end
	end

	// Pulled and released lengths inside a burst
	always_ff @(posedge clk) begin
		if (rst) begin
			low_len <= '0;
			high_len <= '0;
		end else if (clk_en) begin
			low_len <= line_oe ? low_len + 1'b1 : '0;
			high_len <= (state == ST_HIGH) ? high_len + 1'b1 : '0;
		end
	end

	// Pulses started in the current burst
	always_ff @(posedge clk) begin
		if (rst) begin
			sent <= '0;
			oe_d <= 1'b0;
		end else if (clk_en) begin
			oe_d <= line_oe;
			if (state == ST_WAIT)
				sent <= '0;
			else if (line_oe && !oe_d)
				sent <= sent + 1'b1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence burst_start_s;
		state == ST_WAIT && $past(state) == ST_STROBE;
	endsequence

	sequence delay_done_s;
		clk_en && state == ST_WAIT && wait_len == cspr_pkg::CNT_W'(REPORT_DELAY - 1);
	endsequence

	sequence low_done_s;
		clk_en && line_oe && low_len == cspr_pkg::CNT_W'(PULSE_PERIOD / 2 - 1);
	endsequence

	sequence high_done_s;
		clk_en && state == ST_HIGH
		&& high_len == cspr_pkg::CNT_W'(PULSE_PERIOD - PULSE_PERIOD / 2 - 1);
	endsequence

	delay_length_a: assert property (@(posedge clk) disable iff (rst)
		delay_done_s |=> line_oe) else $error("report delay too long");
	delay_floor_a: assert property (@(posedge clk) disable iff (rst)
		($rose(line_oe) && $past(state) == ST_WAIT)
		|-> $past(wait_len) == cspr_pkg::CNT_W'(REPORT_DELAY - 1))
		else $error("report delay too short");
	pulse_low_a: assert property (@(posedge clk) disable iff (rst)
		low_done_s |=> !line_oe) else $error("pulse held low too long");
	pulse_low_max_a: assert property (@(posedge clk) disable iff (rst)
		line_oe |-> low_len < cspr_pkg::CNT_W'(PULSE_PERIOD / 2))
		else $error("pulse low overrun");
	pulse_high_a: assert property (@(posedge clk) disable iff (rst)
		high_done_s |=> state != ST_HIGH) else $error("pulse gap too long");
	burst_count_a: assert property (@(posedge clk) disable iff (rst)
		($fell(busy) && $past(state) == ST_HIGH) |-> sent == code)
		else $error("pulse count differs from status");
	clk_hold_a: assert property (@(posedge clk) disable iff (rst)
		!clk_en |=> $stable(state) && $stable(cnt) && $stable(left) && $stable(code))
		else $error("state moved while frozen");
	reset_idle_a: assert property (@(posedge clk) rst |=> !busy && !line_oe)
		else $error("line pulled after reset");

	never_drive_high_a: assert property (@(posedge clk) disable iff (rst)
		line_oe |-> !line_out) else $error("line driven high");
	drive_only_burst_a: assert property (@(posedge clk) disable iff (rst)
		line_oe |-> state == ST_LOW) else $error("line driven outside burst");
	wait_after_rise_a: assert property (@(posedge clk) disable iff (rst || !clk_en)
		burst_start_s |-> !line_oe) else $error("reply before delay");
	strobe_to_wait_a: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state == ST_STROBE && line_in) |=> state == ST_WAIT)
		else $error("rise not detected");
	overlong_drop_a: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state == ST_STROBE && !line_in && cnt == cspr_pkg::CNT_W'(STROBE_MAX - 1))
		|=> state == ST_IDLE) else $error("overlong strobe kept");
	code_range_a: assert property (@(posedge clk) disable iff (rst)
		state == ST_WAIT |-> (code >= cspr_pkg::N_DIE_HOT && code <= cspr_pkg::N_ERROR
		&& !(code > cspr_pkg::N_OVER_V && code < cspr_pkg::N_HIGH_BASE)))
		else $error("bad pulse count");
	fault_first_a: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state == ST_STROBE && line_in && die_over_temp)
		|=> code == cspr_pkg::N_DIE_HOT) else $error("die fault count wrong");
	high_range_a: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state == ST_STROBE && line_in && current_range_select && !die_over_temp
		&& !bat_temp_fault && !over_voltage && phase == cspr_pkg::PH_CC)
		|=> code == cspr_pkg::N_HIGH_BASE + 5'h02) else $error("high setting count wrong");
	low_range_a: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state == ST_STROBE && line_in && !current_range_select && !die_over_temp
		&& !bat_temp_fault && !over_voltage && phase == cspr_pkg::PH_END)
		|=> code == cspr_pkg::N_LOW_BASE + 5'h04) else $error("low setting count wrong");
	pulse_fall_a: assert property (@(posedge clk) disable iff (rst)
		$rose(line_oe) |-> $past(state) == ST_WAIT || $past(state) == ST_HIGH)
		else $error("pulse started out of sequence");
endmodule

// *** cspr_host.sv ***
// Host model that strobes the status line and counts reply pulses
`timescale 1ns/1ps
module cspr_host #(parameter int P = 4) (
	// Clock and shared line
	input wire logic clk,
	input wire logic line,
	output logic pull
);
	int n, gap, bad_per, t, last;
	logic prev;
	initial pull = 1'b0;
	// Strobe low, release, then count falling edges until the line idles
	task automatic poll(input int low_cyc);
		pull <= 1'b1;
		repeat (low_cyc) @(posedge clk);
		pull <= 1'b0;
		n = 0;
		t = 0;
		gap = 0;
		bad_per = 0;
		last = 0;
		prev = 1'b0;
		while (t - last < 3 * P + 20) begin
			@(posedge clk);
			t++;
			if (!line && prev) begin
				if (n == 0) gap = t;
				else if (t - last != P) bad_per++;
				n++;
				last = t;
			end
			prev = line;
		end
	endtask
endmodule

// *** tb_charge_status_pulse_reporter.sv ***
// Self-checking bench for the charge status pulse reporter
`timescale 1ns/1ps
module tb_charge_status_pulse_reporter;
	localparam int R = 4, P = 4, M = 20;
	logic clk = 0, rst = 1, clk_en = 1, sel = 0, dot = 0, btf = 0, ov = 0;
	cspr_pkg::cspr_phase_t ph = cspr_pkg::PH_COND;
	logic line_out, line_oe, busy, pull;
	logic [31:0] seed = 32'h0000_0034;
	logic [31:0] r;
	int miscompares = 0, checked = 0, cyc = 0, k;
	// Pulled-up line, low while any party pulls
	wire logic line = !((line_oe && !line_out) || pull);
	cspr_reporter #(.REPORT_DELAY(R), .PULSE_PERIOD(P), .STROBE_MAX(M)) cspr_reporter_i (
		.clk(clk), .rst(rst), .clk_en(clk_en), .line_in(line), .line_out(line_out),
		.line_oe(line_oe), .current_range_select(sel), .die_over_temp(dot),
		.bat_temp_fault(btf), .over_voltage(ov), .phase(ph), .busy(busy));
	cspr_host #(.P(P)) cspr_host_i (.clk(clk), .line(line), .pull(pull));
	// Xorshift source and expected count
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int exp_n(logic s, logic d, logic b, logic o, int p);
		return d ? 1 : b ? 2 : o ? 3 : p > 4 ? 23 : (s ? 13 : 18) + p;
	endfunction
	task automatic cmp(input int got, input int want, input string m);
		checked++;
		if (got !== want) begin
			miscompares++;
			$display("BAD %0t %s got %0d want %0d", $time, m, got, want);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic want, input string m);
		checked++;
		if (got !== want) begin
			miscompares++;
			$display("BAD %0t %s got %b want %b", $time, m, got, want);
		end
	endtask
	task automatic close_out();
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Clock and hang guard
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	// Table of every code first, then random states
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 40; i++) begin
			r = xs();
			k = i - 3;
			sel <= (i < 15) ? i < 9 : r[0];
			dot <= (i < 15) ? i == 0 : r[1] & r[2];
			btf <= (i < 15) ? i == 1 : r[3] & r[4];
			ov <= (i < 15) ? i == 2 : r[5] & r[6];
			ph <= cspr_pkg::cspr_phase_t'((i < 15) ? (k < 0 ? 0 : k % 6) : r[10:8] % 6);
			if (i > 15 && r[20]) begin
				clk_en <= 1'b0;
				repeat (3) @(posedge clk);
				clk_en <= 1'b1;
			end
			@(posedge clk);
			cspr_host_i.poll(i % 3 == 0 ? 5 : i == 20 ? M + 5 : 1 + r[15:12] % 15);
			cmp(cspr_host_i.n, exp_n(sel, dot, btf, ov, int'(ph)), "count");
			cmp(cspr_host_i.gap, R + 2, "delay");
			cmp(cspr_host_i.bad_per, 0, "period");
			cmp_bit(busy, 1'b0, "idle");
		end
		close_out();
	end
endmodule
